// ===== rtl/gpp_ports.sv
// Function
// - all ports but port 1 set each pin input or output; port 1 input only
// - pull-ups only on ports 0, 2-8, 10, 12, and only while input
// - ports 0, 2, 3, 7, 8, 10, 12 have one pull-up enable per pin
// - ports 4, 5, 6 have one pull-up enable for the whole port
// - port 9 is open-drain, per-pin direction, no pull-up
`timescale 1ns/1ps

module gpp_ports (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              reset,
	// software configuration, one row per port
	input  wire gpp_pkg::gpp_bus_t dir_out_wdata,
	input  wire logic [13:0]       dir_out_we,
	input  wire gpp_pkg::gpp_bus_t latch_wdata,
	input  wire logic [13:0]       latch_we,
	input  wire gpp_pkg::gpp_bus_t pull_up_wdata,
	input  wire logic [13:0]       pull_up_we,
	// software readback
	output gpp_pkg::gpp_bus_t      pin_value,
	output gpp_pkg::gpp_bus_t      dir_out_state,
	output gpp_pkg::gpp_bus_t      pull_up_state,
	// pins
	input  wire gpp_pkg::gpp_bus_t pin_in,
	output gpp_pkg::gpp_bus_t      pin_out,
	output gpp_pkg::gpp_bus_t      pin_oe,
	output gpp_pkg::gpp_bus_t      pull_up
);
	import gpp_pkg::*;

	gpp_state_t state_reg;
	gpp_state_t state_next;

	////////////////////////////////////////////////////////////////////////
	// row helpers, shared by the write, drive and readback stages

	// unfitted pins never hold a one
	function automatic logic [PORT_W-1:0] fit_row(
		input int                p,
		input logic [PORT_W-1:0] row
	);
		fit_row = row & PIN_MASK[p];
	endfunction

	// direction as stored; the input-only port ignores the write
	function automatic logic [PORT_W-1:0] dir_store(
		input int                p,
		input logic [PORT_W-1:0] row
	);
		if (p == INPUT_ONLY_PORT) begin
			dir_store = RST_DIR_OUT;
		end else begin
			dir_store = fit_row(p, row);
		end
	endfunction

	// pull-up enable as stored, shaped by what the port supports
	function automatic logic [PORT_W-1:0] pu_store(
		input int                p,
		input logic [PORT_W-1:0] row
	);
		pu_store = RST_PU;
		unique case (PU_KIND[p])
			GPP_PU_BIT: begin
				pu_store = fit_row(p, row);
			end
			GPP_PU_PORT: begin
				// one enable for the port; the other bits stay clear
				pu_store[PU_PORT_BIT] = row[PU_PORT_BIT];
			end
			GPP_PU_NONE: begin
				// no resistor fitted, so nothing is kept
				pu_store = RST_PU;
			end
		endcase
	endfunction

	// resistor on only for input pins whose enable is set
	function automatic logic [PORT_W-1:0] pull_drive(
		input int                p,
		input logic [PORT_W-1:0] pu_en,
		input logic [PORT_W-1:0] dir
	);
		logic [PORT_W-1:0] want;
		want = RST_PU;
		unique case (PU_KIND[p])
			GPP_PU_BIT: begin
				want = pu_en;
			end
			GPP_PU_PORT: begin
				want = {PORT_W{pu_en[PU_PORT_BIT]}};
			end
			GPP_PU_NONE: begin
				want = RST_PU;
			end
		endcase
		pull_drive = fit_row(p, want & ~dir);
	endfunction

	// output enable; the open-drain port only ever pulls low
	function automatic logic [PORT_W-1:0] drive_oe(
		input int                p,
		input logic [PORT_W-1:0] dir,
		input logic [PORT_W-1:0] latch
	);
		if (p == OPEN_DRAIN_PORT) begin
			drive_oe = fit_row(p, dir & ~latch);
		end else begin
			drive_oe = fit_row(p, dir);
		end
	endfunction

	// drive level; a one on the open-drain port releases the pin,
	// so its level is never driven high and needs a board pull-up
	function automatic logic [PORT_W-1:0] drive_out(
		input int                p,
		input logic [PORT_W-1:0] latch
	);
		if (p == OPEN_DRAIN_PORT) begin
			drive_out = RST_PIN;
		end else begin
			drive_out = fit_row(p, latch);
		end
	endfunction

	// outputs read back their latch, inputs the synchronised pin;
	// an open-drain output reads its latch, not the wire
	function automatic logic [PORT_W-1:0] read_back(
		input int                p,
		input logic [PORT_W-1:0] dir,
		input logic [PORT_W-1:0] latch,
		input logic [PORT_W-1:0] pin
	);
		read_back = fit_row(p, (dir & latch) | (~dir & pin));
	endfunction

	// state after reset: every pin an input, no pull-up, nothing driven
	function automatic gpp_state_t reset_state();
		gpp_state_t s;
		for (int p = 0; p < NUM_PORTS; p++) begin
			s.dir_out[p]   = RST_DIR_OUT;
			s.latch[p]     = RST_LATCH;
			s.pu_en[p]     = RST_PU;
			s.sync1[p]     = RST_PIN;
			s.sync2[p]     = RST_PIN;
			s.pin_out[p]   = RST_PIN;
			s.pin_oe[p]    = RST_DIR_OUT;
			s.pull_up[p]   = RST_PU;
			s.pin_value[p] = RST_PIN;
		end
		reset_state = s;
	endfunction

	////////////////////////////////////////////////////////////////////////

	always_comb begin
		state_next = state_reg;

		// pins pass two flops before anything reads them
		state_next.sync1 = pin_in;
		state_next.sync2 = state_reg.sync1;

		// software writes, one strobe per port, all ports in parallel
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (dir_out_we[p]) begin
				state_next.dir_out[p] =
					dir_store(p, dir_out_wdata[p]);
			end

			if (latch_we[p]) begin
				state_next.latch[p] = fit_row(p, latch_wdata[p]);
			end

			if (pull_up_we[p]) begin
				// port-wide kinds keep only their enable bit
				state_next.pu_en[p] =
					pu_store(p, pull_up_wdata[p]);
			end
		end

		// drive stage: registered so every pin output comes from a flop
		// oe and pull-up share one stored direction, so never overlap
		for (int p = 0; p < NUM_PORTS; p++) begin
			state_next.pin_out[p] =
				drive_out(p, state_reg.latch[p]);

			state_next.pin_oe[p] =
				drive_oe(p, state_reg.dir_out[p],
					state_reg.latch[p]);

			state_next.pull_up[p] =
				pull_drive(p, state_reg.pu_en[p],
					state_reg.dir_out[p]);
		end

		// readback: a pin change shows three clocks later
		for (int p = 0; p < NUM_PORTS; p++) begin
			state_next.pin_value[p] = read_back(p,
				state_reg.dir_out[p], state_reg.latch[p],
				state_reg.sync2[p]);
		end

		// synchronous reset wins over any write in the same cycle
		if (reset) begin
			state_next = reset_state();
		end
	end

	always_ff @(posedge clk) begin
		state_reg <= state_next;
	end

	////////////////////////////////////////////////////////////////////////

	assign pin_value     = state_reg.pin_value;
	assign dir_out_state = state_reg.dir_out;
	assign pull_up_state = state_reg.pu_en;
	assign pin_out       = state_reg.pin_out;
	assign pin_oe        = state_reg.pin_oe;
	assign pull_up       = state_reg.pull_up;

endmodule

// ===== rtl/gpp_pkg.sv
package gpp_pkg;

	// port numbering: index 11 has no pins on this device
	localparam int NUM_PORTS = 14;
	localparam int PORT_W    = 8;

	// pins fitted on each port, one bit per pin
	localparam logic [7:0] PIN_MASK [NUM_PORTS] = '{
		8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
		8'h07, 8'hff, 8'h3f, 8'h0f, 8'h00, 8'hff, 8'h03};

	// pull-up support: per pin, per port, or none
	typedef enum logic [1:0] {
		GPP_PU_NONE = 2'b00,
		GPP_PU_BIT  = 2'b01,
		GPP_PU_PORT = 2'b11
	} gpp_pu_kind_t;

	localparam gpp_pu_kind_t PU_KIND [NUM_PORTS] = '{
		GPP_PU_BIT,  GPP_PU_NONE, GPP_PU_BIT,  GPP_PU_BIT,
		GPP_PU_PORT, GPP_PU_PORT, GPP_PU_PORT, GPP_PU_BIT,
		GPP_PU_BIT,  GPP_PU_NONE, GPP_PU_BIT,  GPP_PU_NONE,
		GPP_PU_BIT,  GPP_PU_NONE};

	localparam int INPUT_ONLY_PORT = 1;
	localparam int OPEN_DRAIN_PORT = 9;
	// row bit that carries a port-wide pull-up enable
	localparam int PU_PORT_BIT     = 0;

	// reset values
	localparam logic [7:0] RST_DIR_OUT = 8'h00;
	localparam logic [7:0] RST_LATCH   = 8'h00;
	localparam logic [7:0] RST_PU      = 8'h00;
	localparam logic [7:0] RST_PIN     = 8'h00;

	typedef logic [NUM_PORTS-1:0][PORT_W-1:0] gpp_bus_t;

	typedef struct packed {
		gpp_bus_t dir_out;
		gpp_bus_t latch;
		gpp_bus_t pu_en;
		gpp_bus_t sync1;
		gpp_bus_t sync2;
		gpp_bus_t pin_out;
		gpp_bus_t pin_oe;
		gpp_bus_t pull_up;
		gpp_bus_t pin_value;
	} gpp_state_t;

endpackage

// ===== verif/gpp_board.sv
`timescale 1ns/1ps
// undriven, unpulled lines follow a toggling board pattern, never a stale level
module gpp_board import gpp_pkg::*; (
	input  wire gpp_bus_t pin_out,
	input  wire gpp_bus_t pin_oe,
	input  wire gpp_bus_t pull_up,
	input  wire gpp_bus_t ext,
	output gpp_bus_t      pin_in
);
	assign pin_in = pin_oe & pin_out | ~pin_oe & (pull_up | ext);
endmodule

// ===== verif/gpp_ports_sva.sv
`timescale 1ns/1ps
module gpp_sva import gpp_pkg::*; (
	input wire logic     clk,
	input wire logic     reset,
	input wire gpp_bus_t pin_oe,
	input wire gpp_bus_t pin_out,
	input wire gpp_bus_t pull_up,
	input wire gpp_bus_t dir_out_state,
	input wire gpp_bus_t pull_up_state
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_input_only: assert property (pin_oe[1] == 8'h00)
		else $error("input-only port drives");
	a_oe_follows_dir: assert property (
		pin_oe[2] == $past(dir_out_state[2]))
		else $error("direction not applied");
	a_bit_pull: assert property (
		pull_up[2] == ($past(pull_up_state[2])
		& ~$past(dir_out_state[2])))
		else $error("pin pull-up");
	a_port_pull: assert property (
		pull_up[4] == ({8{$past(pull_up_state[4][PU_PORT_BIT])}}
		& ~$past(dir_out_state[4])))
		else $error("port pull-up");
	a_pull_input: assert property (
		(pull_up[0] & pin_oe[0]) == 8'h00)
		else $error("pull-up on output");
	a_drain_low: assert property (
		pin_out[9] == 8'h00 && pull_up[9] == 8'h00)
		else $error("open-drain port drives high");
	a_drain_dir: assert property (
		(pin_oe[9] & ~$past(dir_out_state[9])) == 8'h00)
		else $error("open-drain pin pulls while input");
	a_reset_quiet: assert property (disable iff (1'b0) reset |=>
		pin_oe == '0 && pull_up == '0) else $error("pins active after reset");
endmodule
bind gpp_ports gpp_sva u_sva (.clk(clk), .reset(reset), .pin_oe(pin_oe),
	.pin_out(pin_out), .pull_up(pull_up), .dir_out_state(dir_out_state),
	.pull_up_state(pull_up_state));

// ===== verif/gpp_ports_tb.sv
`timescale 1ns/1ps
module gpp_ports_tb;
	import gpp_pkg::*;
	logic        clk = 0, reset = 1;
	logic [13:0] dwe = '0, lwe = '0, pwe = '0;
	gpp_bus_t    wd = '0, ext = '0, pv, ds, ps, pin, po, oe, pu;
	int          mismatches = 0, check_count = 0;
	always #2 clk = ~clk;
	always @(negedge clk) ext <= ~ext;
	gpp_ports u_dut (.clk(clk), .reset(reset), .dir_out_wdata(wd),
		.dir_out_we(dwe), .latch_wdata(wd), .latch_we(lwe),
		.pull_up_wdata(wd), .pull_up_we(pwe), .pin_value(pv),
		.dir_out_state(ds), .pull_up_state(ps), .pin_in(pin),
		.pin_out(po), .pin_oe(oe), .pull_up(pu));
	gpp_board u_board (.pin_out(po), .pin_oe(oe), .pull_up(pu), .ext(ext),
		.pin_in(pin));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		check_count++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask
	// same row to every port at once; 4 cycles cover the 3-edge readback
	task automatic wr(int k, logic [7:0] d);
		@(negedge clk);
		wd = {NUM_PORTS{d}};
		if (k == 0) begin
			dwe = '1;
		end else if (k == 1) begin
			lwe = '1;
		end else begin
			pwe = '1;
		end
		@(negedge clk);
		{dwe, lwe, pwe} = '0;
		repeat (4) @(negedge clk);
	endtask
	task automatic t_pull(logic [7:0] d, logic [7:0] dir);
		logic [7:0] e, st, dx;
		wr(0, dir);
		wr(2, d);
		for (int p = 0; p < NUM_PORTS; p++) begin
			st = 8'h00;
			e = 8'h00;
			if (PU_KIND[p] == GPP_PU_BIT) begin
				st = d & PIN_MASK[p];
				e = st;
			end else if (PU_KIND[p] == GPP_PU_PORT) begin
				st[PU_PORT_BIT] = d[PU_PORT_BIT];
				e = {8{d[PU_PORT_BIT]}} & PIN_MASK[p];
			end
			dx = dir & PIN_MASK[p];
			if (p == INPUT_ONLY_PORT) dx = 8'h00;
			e = e & ~dx;
			chk("dir", ds[p], dx);
			chk("pu_en", ps[p], st);
			chk("pull", pu[p], e);
			chk("val", pv[p] & e, e);
		end
	endtask
	task automatic t_drive();
		logic [7:0] e;
		wr(1, 8'h5a);
		wr(0, 8'hff);
		for (int p = 0; p < NUM_PORTS; p++) begin
			e = PIN_MASK[p];
			if (p == INPUT_ONLY_PORT) e = 8'h00;
			if (p == OPEN_DRAIN_PORT) e = PIN_MASK[p] & ~8'h5a;
			chk("oe", oe[p], e);
			chk("pull", pu[p], 8'h00);
		end
		chk("out9", po[9], 8'h00);
		chk("out2", po[2], 8'h5a);
		chk("val2", pv[2], 8'h5a);
	endtask
	// reset at any time leaves every pin an undriven, unpulled input
	task automatic t_reset(int n);
		reset = 1;
		repeat (n) @(negedge clk);
		reset = 0;
		for (int p = 0; p < NUM_PORTS; p++) begin
			chk("rst", oe[p] | pu[p] | ds[p] | ps[p], 8'h00);
			chk("rst_out", po[p] | pv[p], 8'h00);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		t_reset(10);
		t_pull(8'hff, 8'h00);
		t_pull(8'hff, 8'h0f);
		t_pull(8'hfe, 8'h0f);
		t_drive();
		t_reset(2);
		tally_and_finish();
	end
	initial begin
		#2000;
		mismatches++;
		tally_and_finish();
	end
endmodule
